// ### pkg/sbstap_pkg.sv
// Package of constants and types for the SRAM boundary-scan test port
// ---------------------------------------------------------------------
// Functional notes
// - Sample TMS and TDI on rising TCK; change TDO on falling TCK only.
// - Undriven TMS or TDI reads as logic high through pull-ups.
// - Serial data enters the selected register MSB; TDO shows its LSB.
// - Five TMS-high rising edges reset the port; memory keeps running.
// - Power-up resets the port and floats TDO without any TCK.
// - Three-bit instruction register; loads identification code on reset.
// - Capture-IR loads binary 01 into the two lowest instruction bits.
// - Only one data register sits between TDI and TDO, chosen by instruction.
// - Bypass is one flip-flop, cleared on capture, shifted in Shift-DR.
// - Capture-DR loads all pin values into the boundary chain, then shifts.
// - Identification instruction captures a fixed 32-bit code, shifted out.
// - Instruction shifts in Shift-IR and takes effect at Update-IR.
// - All-zero instruction acts exactly as sample/preload, never drives pins.
// - No way to apply memory signals or preload buffers through the chain.
// - High-impedance sampling connects the boundary chain during Shift-DR.
// - Sample/preload snapshots every pin into the chain at Capture-DR.
// - Update-DR under sample/preload changes nothing, like Pause-DR.
// - Codes: identification 001, high-z sampling 010, sample/preload 100.
// - High-z sampling floats the memory outputs; all-zero code does not.
// - Id word: revision 31:29, device 28:12, vendor 11:1, bit 0 one.
// ---------------------------------------------------------------------
package sbstap_pkg;

  localparam int IR_WIDTH = 3;
  localparam int ID_WIDTH = 32;
  localparam int BSR_WIDTH = 107;

  // Instruction codes
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPZ = 3'h2;
  localparam logic [2:0] INS_SAMPLE = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE = 2'h1;

  // Identification fields (values arbitrary, not any real part)
  localparam int ID_REV_LSB = 29;
  localparam int ID_DEV_LSB = 12;
  localparam int ID_VEND_LSB = 1;
  localparam logic [2:0] ID_REV = 3'h2;
  localparam logic [16:0] ID_DEV = 17'h0a5a5;
  localparam logic [10:0] ID_VEND = 11'h123;
  localparam logic [31:0] ID_WORD = (32'(ID_REV) << ID_REV_LSB)
    | (32'(ID_DEV) << ID_DEV_LSB) | (32'(ID_VEND) << ID_VEND_LSB) | 32'h1;

  // Link timing
  localparam int CLK_HZ = 50000000;
  localparam int TCK_MAX_HZ = 10000000;
  localparam int RESET_TMS_EDGES = 5;

  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SELDR = 16'h0004,
    ST_CAPDR = 16'h0008, ST_SHDR = 16'h0010, ST_EX1DR = 16'h0020,
    ST_PADR = 16'h0040, ST_EX2DR = 16'h0080, ST_UPDR = 16'h0100,
    ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR = 16'h0800,
    ST_EX1IR = 16'h1000, ST_PAIR = 16'h2000, ST_EX2IR = 16'h4000,
    ST_UPIR = 16'h8000
  } sbstap_state_type;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbstap_pins_type;

  typedef struct packed {
    logic tdo;
    logic tdoEn;
  } sbstap_out_type;

endpackage

// ### verilog/sbstap_sync.sv
// Two-stage synchroniser with TCK edge finder for the test pins
`timescale 1ns/10ps
`default_nettype none
module sbstap_sync
  import sbstap_pkg::*;
(
  // Clock and reset
  input wire logic coreClk,
  input wire logic srst,
  // Raw pins and synced copies
  input wire sbstap_pkg::sbstap_pins_type pinRaw,
  output sbstap_pkg::sbstap_pins_type pinSync,
  output logic tckRise,
  output logic tckFall
);
  import sbstap_pkg::*;

  typedef struct packed {
    sbstap_pins_type s1;
    sbstap_pins_type s2;
    logic tckPrev;
  } sbstap_sync_type;

  sbstap_sync_type state_q, state_d;

  always_comb
  begin
    state_d = state_q;
    state_d.s1 = pinRaw;
    state_d.s2 = state_q.s1;
    state_d.tckPrev = state_q.s2.tck;
  end

  always_ff @(posedge coreClk)
  begin
    if (srst)
    begin
      // Pull-ups: idle pins read high; TCK parks low
      state_q <= '{s1: 3'h3, s2: 3'h3, tckPrev: 1'b0};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign pinSync = state_q.s2;
  assign tckRise = state_q.s2.tck & ~state_q.tckPrev;
  assign tckFall = ~state_q.s2.tck & state_q.tckPrev;
endmodule
`default_nettype wire

// ### verilog/sbstap_top.sv
// Boundary-scan test access port of the synchronous SRAM
`timescale 1ns/10ps
`default_nettype none
module sbstap_top
  import sbstap_pkg::*;
(
  // Clock and reset
  input wire logic coreClk,
  input wire logic srst,
  // Test pins (pull-up resolution done outside)
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoEn,
  // Pin ring sampled by the boundary chain
  input wire logic [106:0] pinRing,
  // Memory output buffers forced to high impedance
  output logic memOutHiZ
);
  import sbstap_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    sbstap_state_type st;
    logic [2:0] irShift;
    logic [2:0] irActive;
    logic bypass;
    logic [31:0] idReg;
    logic [106:0] bsr;
    logic tdo;
    logic tdoEn;
    logic hiZ;
    logic [2:0] tmsHighCnt;
  } sbstap_top_type;

  sbstap_top_type state_q, state_d;
  sbstap_pins_type pinSync;
  logic tckRise;
  logic tckFall;
  logic [106:0] ringSync1, ringSync2;
  sbstap_pins_type pinRaw;

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  assign pinRaw = '{tck: tck, tms: tms, tdi: tdi};

  sbstap_sync uSync (
    .coreClk(coreClk),
    .srst(srst),
    .pinRaw(pinRaw),
    .pinSync(pinSync),
    .tckRise(tckRise),
    .tckFall(tckFall)
  );

  // Ring pins come from a faster memory clock; two flops before capture
  always_ff @(posedge coreClk)
  begin
    ringSync1 <= pinRing;
    ringSync2 <= ringSync1;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic sbstap_state_type nextState(sbstap_state_type s,
                                                 logic m);
    case (s)
      ST_RESET: nextState = m ? ST_RESET : ST_IDLE;
      ST_IDLE: nextState = m ? ST_SELDR : ST_IDLE;
      ST_SELDR: nextState = m ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: nextState = m ? ST_EX1DR : ST_SHDR;
      ST_SHDR: nextState = m ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: nextState = m ? ST_UPDR : ST_PADR;
      ST_PADR: nextState = m ? ST_EX2DR : ST_PADR;
      ST_EX2DR: nextState = m ? ST_UPDR : ST_SHDR;
      ST_UPDR: nextState = m ? ST_SELDR : ST_IDLE;
      ST_SELIR: nextState = m ? ST_RESET : ST_CAPIR;
      ST_CAPIR: nextState = m ? ST_EX1IR : ST_SHIR;
      ST_SHIR: nextState = m ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: nextState = m ? ST_UPIR : ST_PAIR;
      ST_PAIR: nextState = m ? ST_EX2IR : ST_PAIR;
      ST_EX2IR: nextState = m ? ST_UPIR : ST_SHIR;
      ST_UPIR: nextState = m ? ST_SELDR : ST_IDLE;
      default: nextState = ST_RESET;
    endcase
  endfunction

  // Data register choice; undefined codes fall to bypass
  function automatic logic [1:0] drSelect(logic [2:0] ins);
    case (ins)
      INS_IDCODE: drSelect = 2'h1;
      INS_EXTEST, INS_SAMPZ, INS_SAMPLE: drSelect = 2'h2;
      default: drSelect = 2'h0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [1:0] sel;

  always_comb
  begin
    state_d = state_q;
    sel = drSelect(state_q.irActive);
    if (tckRise)
    begin
      // Data moves on rising TCK only
      state_d.st = nextState(state_q.st, pinSync.tms);
      // Redundant with the machine, but keeps the five-edge reset explicit
      if (pinSync.tms)
      begin
        if (state_q.tmsHighCnt != 3'(RESET_TMS_EDGES))
        begin
          state_d.tmsHighCnt = state_q.tmsHighCnt + 3'h1;
        end
      end
      else
      begin
        state_d.tmsHighCnt = 3'h0;
      end
      if (pinSync.tms &&
          state_q.tmsHighCnt == 3'(RESET_TMS_EDGES - 1))
      begin
        state_d.st = ST_RESET;
      end
      case (state_q.st)
        ST_CAPIR:
        begin
          state_d.irShift = {state_q.irShift[2], IR_CAPTURE};
        end
        ST_SHIR:
        begin
          state_d.irShift = {pinSync.tdi, state_q.irShift[2:1]};
        end
        ST_CAPDR:
        begin
          state_d.bypass = 1'b0;
          if (sel == 2'h1)
          begin
            state_d.idReg = ID_WORD;
          end
          if (sel == 2'h2)
          begin
            state_d.bsr = ringSync2;
          end
        end
        ST_SHDR:
        begin
          case (sel)
            2'h1: state_d.idReg = {pinSync.tdi, state_q.idReg[31:1]};
            2'h2: state_d.bsr = {pinSync.tdi, state_q.bsr[106:1]};
            default: state_d.bypass = pinSync.tdi;
          endcase
        end
        // Update-DR drives nothing back: no preload path exists
        ST_UPDR:
        begin
          state_d.bsr = state_q.bsr;
        end
        default:
        begin
          state_d.irShift = state_q.irShift;
        end
      endcase
      // Instruction goes live on the edge that enters Update-IR
      if (state_d.st == ST_UPIR)
      begin
        state_d.irActive = state_q.irShift;
      end
      if (state_d.st == ST_RESET)
      begin
        state_d.irActive = INS_IDCODE;
        state_d.irShift = INS_IDCODE;
      end
    end
    if (tckFall)
    begin
      // TDO only changes on falling TCK
      state_d.tdoEn = (state_q.st == ST_SHDR) || (state_q.st == ST_SHIR);
      if (state_q.st == ST_SHIR)
      begin
        state_d.tdo = state_q.irShift[0];
      end
      else
      begin
        case (sel)
          2'h1: state_d.tdo = state_q.idReg[0];
          2'h2: state_d.tdo = state_q.bsr[0];
          default: state_d.tdo = state_q.bypass;
        endcase
      end
    end
    // Only high-z sampling floats memory outputs; all-zero code does not
    state_d.hiZ = (state_q.irActive == INS_SAMPZ);
  end

  always_ff @(posedge coreClk)
  begin
    if (srst)
    begin
      // Comes up reset with TDO floating, no TCK needed
      state_q.st <= ST_RESET;
      state_q.irShift <= INS_IDCODE;
      state_q.irActive <= INS_IDCODE;
      state_q.bypass <= 1'b0;
      state_q.idReg <= 32'h0;
      state_q.bsr <= '0;
      state_q.tdo <= 1'b0;
      state_q.tdoEn <= 1'b0;
      state_q.hiZ <= 1'b0;
      state_q.tmsHighCnt <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign tdo = state_q.tdo;
  assign tdoEn = state_q.tdoEn;
  assign memOutHiZ = state_q.hiZ;
endmodule
`default_nettype wire

// ### sim/sbstap_top_asserts.sv
// Concurrent checks on the scan port pins of the test access port
`timescale 1ns/10ps
`default_nettype none
module sbstap_top_asserts
(
  // Clock and reset
  input wire logic coreClk,
  input wire logic srst,
  // Scan pins and ring
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdoEn,
  input wire logic [106:0] pinRing,
  input wire logic memOutHiZ
);
  // ---------------------------------------------------------------
  // Count of consecutive tck rises with tms high
  // ---------------------------------------------------------------
  logic tckPrev_q;
  logic [2:0] highCnt_q;
  logic hit5_q;
  logic tckRise;
  assign tckRise = tck && !tckPrev_q;
  always_ff @(posedge coreClk)
  begin
    tckPrev_q <= tck;
    hit5_q <= !srst && tckRise && tms && highCnt_q == 3'h4;
    if (srst || (tckRise && !tms))
      highCnt_q <= 3'h0;
    else if (tckRise && highCnt_q != 3'h7)
      highCnt_q <= highCnt_q + 3'h1;
  end
  default clocking cb @(posedge coreClk); endclocking
  default disable iff (srst);
  a_tdo_after_fall: assert property ($changed(tdo) |-> !tck && !$past(tck, 3))
    else $error("tdo moved outside a tck low phase");
  a_en_rise_low: assert property ($rose(tdoEn) |-> !tck && !$past(tck, 3))
    else $error("tdoEn rose outside a tck low phase");
  a_en_fall_low: assert property ($fell(tdoEn) |-> !tck)
    else $error("tdoEn fell while tck high");
  a_tdo_hold_high: assert property (tck && $past(tck) && $past(tck, 2) |-> $stable(tdo))
    else $error("tdo moved during tck high");
  a_reset_quiet: assert property ($fell(srst) |-> !tdo && !tdoEn && !memOutHiZ)
    else $error("outputs not quiet after reset");
  a_five_tms: assert property (hit5_q |-> ##[1:8] (!memOutHiZ && !tdoEn))
    else $error("five tms highs did not reset the port");
  a_hiz_at_update: assert property ($changed(memOutHiZ) && !$past(srst) |-> $past(tck, 2) && $past(tms, 2))
    else $error("instruction changed away from an update edge");
  a_hiz_no_shift: assert property ($rose(memOutHiZ) |-> !tdoEn)
    else $error("high impedance began during a shift");
endmodule
bind sbstap_top sbstap_top_asserts u_asserts (.coreClk(coreClk), .srst(srst),
  .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn),
  .pinRing(pinRing), .memOutHiZ(memOutHiZ));
`default_nettype wire

// ### sim/sbstap_ctl_model.sv
// Behavioural boundary-scan controller driving the test pins
`timescale 1ns/10ps
`default_nettype none
module sbstap_ctl_model
(
  // Pacing clock
  input wire logic coreClk,
  // Scan pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  logic pinOe = 1'b0;
  logic tmsV = 1'b1;
  logic tdiV = 1'b1;
  initial tck = 1'b0; // Parked low until used
  // Released pins read high through the pull-ups
  assign tms = pinOe ? tmsV : 1'b1;
  assign tdi = pinOe ? tdiV : 1'b1;
  // One tck period; tms and tdi move on the fall, tdo read before next fall
  task automatic tick(input logic oe, input logic m, input logic d,
    output logic q);
    @(posedge coreClk);
    tck <= 1'b0;
    pinOe <= oe;
    tmsV <= m;
    tdiV <= d;
    repeat (4) @(posedge coreClk); // 80 ns phases stay under 10 MHz
    tck <= 1'b1;
    // Next call waits one more edge, so the high phase is 80 ns too
    repeat (3) @(posedge coreClk);
    q = tdo;
  endtask
endmodule
`default_nettype wire

// ### sim/sbstap_top_tb.sv
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/10ps
`default_nettype none
module sbstap_top_tb;
  import sbstap_pkg::*;
  logic coreClk = 1'b0;
  logic srst = 1'b1;
  logic tck, tms, tdi, tdo, tdoEn, memOutHiZ, q;
  logic [106:0] pinRing = '0;
  logic [127:0] outV, inV;
  logic [2:0] ins;
  int err_total = 0;
  int checks_done = 0;
  always #10 coreClk = ~coreClk;
  sbstap_top u_dut (.coreClk(coreClk), .srst(srst), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn), .pinRing(pinRing),
    .memOutHiZ(memOutHiZ));
  sbstap_ctl_model u_ctl (.coreClk(coreClk), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo));
  // ---------------------------------------------------------------
  // Checking and scan tasks
  // ---------------------------------------------------------------
  task automatic cmp_vec(input string nm, input logic [127:0] e,
    input logic [127:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    cmp_vec(nm, 128'(e), 128'(g));
  endtask
  // From Idle through capture, n shift bits, update, back to Idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
    output logic [127:0] dout);
    logic b;
    dout = '0;
    u_ctl.tick(1'b1, 1'b1, din[0], b);
    if (ir)
      u_ctl.tick(1'b1, 1'b1, din[0], b);
    u_ctl.tick(1'b1, 1'b0, din[0], b);
    u_ctl.tick(1'b1, 1'b0, din[0], b);
    for (int i = 0; i < n; i++)
    begin
      u_ctl.tick(1'b1, i == n - 1, din[i], b);
      dout[i] = b;
    end
    u_ctl.tick(1'b1, 1'b1, ~din[0], b);
    u_ctl.tick(1'b1, 1'b0, din[0], b);
  endtask
  // 123 bits out: captured value first, then what entered at the top
  function automatic logic [127:0] expect_dr(input logic [2:0] c,
    input logic [106:0] r, input logic [127:0] d);
    logic [127:0] e;
    if (c == INS_EXTEST || c == INS_SAMPZ || c == INS_SAMPLE)
      e = 128'({d[15:0], r});
    else if (c == INS_IDCODE)
      e = 128'({d[90:0], ID_REV, ID_DEV, ID_VEND, 1'b1});
    else
      e = 128'({d[121:0], 1'b0});
    return e;
  endfunction
  task automatic tally_and_finish;
    $display("Checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(57702));
    repeat (2) @(posedge coreClk);
    srst <= 1'b0;
    repeat (4) @(posedge coreClk);
    cmp_bit("tdoEn", 1'b0, tdoEn);
    u_ctl.tick(1'b1, 1'b0, 1'b0, q);
    scan(1'b0, 32, '0, outV);
    cmp_vec("idcode", expect_dr(INS_IDCODE, '0, '0) & 128'hffffffff, outV);
    for (int c = 0; c < 8; c++)
    begin
      // Reserved codes are never issued; bypass takes their turn
      ins = (c == 3 || c == 5 || c == 6) ? INS_BYPASS : 3'(c);
      inV = {$urandom, $urandom, $urandom, $urandom};
      @(posedge coreClk);
      pinRing <= 107'({$urandom, $urandom, $urandom, $urandom});
      scan(1'b1, 3, 128'(ins), outV);
      cmp_vec("ircap", 128'h1, outV & 128'h3);
      cmp_bit("memOutHiZ", ins == INS_SAMPZ, memOutHiZ);
      scan(1'b0, 123, inV, outV);
      cmp_vec("dr", expect_dr(ins, pinRing, inV) & {5'h0, {123{1'b1}}}, outV);
    end
    scan(1'b1, 3, 128'(INS_SAMPZ), outV);
    cmp_bit("memOutHiZ", 1'b1, memOutHiZ);
    for (int i = 0; i < 3; i++)
      u_ctl.tick(1'b1, i == 0, 1'b0, q);
    for (int i = 0; i < 5; i++)
      u_ctl.tick(1'b0, 1'b0, 1'b0, q);
    // Reset lands after the last tick returns; let the outputs settle
    repeat (3) @(posedge coreClk);
    cmp_bit("memOutHiZ", 1'b0, memOutHiZ);
    cmp_bit("tdoEn", 1'b0, tdoEn);
    u_ctl.tick(1'b1, 1'b0, 1'b0, q);
    scan(1'b0, 32, '0, outV);
    cmp_vec("idcode", expect_dr(INS_IDCODE, '0, '0) & 128'hffffffff, outV);
    tally_and_finish();
  end
  initial
  begin
    repeat (100000) @(posedge coreClk);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
